// >>> design/scmc_pkg.sv
package scmc_pkg;

  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam logic [7:0] CMC_OFF = 8'h00;
  localparam logic [7:0] WDC_OFF = 8'h01;
  localparam logic [7:0] STAT_OFF = 8'h02;
  localparam logic [7:0] MASK_OFF = 8'h03;
  localparam int HSEL_BIT = 0;
  localparam int IDLE_BIT = 1;
  localparam int HRDY_BIT = 2;
  localparam int LRDY_BIT = 3;
  localparam int FAST_BIT = 4;
  localparam int DIV_LSB = 5;
  localparam int KEEP_BIT = 0;
  localparam logic [7:0] CMC_RESET = 8'h03;
  localparam logic WDC_KEEP_RESET = 1'h0;
  localparam logic [2:0] DIV_LOW_MAX = 3'h1;
  localparam logic [3:0] DIV_SHIFT_BASE = 4'h8;

  // ****************************************************************
  // Oscillator start-up counts, in oscillator cycles
  // ****************************************************************
  localparam logic [10:0] XTAL_CYCLES = 11'h400;
  localparam logic [10:0] HIGH_SPEED_INTERNAL_RC_CYCLES = 11'h010;
  localparam logic [10:0] LOW_SPEED_INTERNAL_RC_CYCLES = 11'h002;

  // ****************************************************************
  // Interrupt events
  // ****************************************************************
  localparam int EV_HRDY = 0;
  localparam int EV_LRDY = 1;
  localparam int EV_HALT = 2;
  localparam int EV_WAKE = 3;
  localparam int EV_W = 4;

  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_IDLE_ON = 5'h02,
    ST_IDLE_OFF = 5'h04,
    ST_SLEEP = 5'h08,
    ST_WAKE = 5'h10
  } scmc_mode_type;

  typedef enum logic [2:0] {
    SRC_OFF = 3'h0,
    SRC_HIGH = 3'h1,
    SRC_DIV = 3'h2,
    SRC_LOW = 3'h3,
    SRC_SUB = 3'h4
  } scmc_src_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scmc_bus_req_type;

  typedef struct packed {
    scmc_mode_type mode;
    logic [2:0] div_sel;
    logic fast_en;
    logic idle_on_halt;
    logic hsel;
    logic keep;
    logic fast_act;
    logic [10:0] hcnt;
    logic [10:0] lcnt;
    logic hready;
    logic lready;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [7:0] rdata;
  } scmc_state_type;

endpackage : scmc_pkg

// >>> design/scmc_top.sv
module scmc_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire scmc_pkg::scmc_bus_req_type reg_req,
  output logic [7:0] reg_rdata,
  input wire logic high_is_crystal,
  input wire logic low_is_crystal,
  input wire logic high_osc_tick,
  input wire logic low_osc_tick,
  input wire logic sub_keep_on,
  input wire logic halt_req,
  input wire logic wake_req,
  output logic cpu_run,
  output logic sysclk_run,
  output scmc_pkg::scmc_src_type sysclk_src,
  output logic [2:0] sysclk_div_shift,
  output logic high_osc_enable,
  output logic low_osc_enable,
  output logic irq
);

  // ****************************************************************
  // State and decoded levels
  // ****************************************************************
  scmc_pkg::scmc_state_type st;
  scmc_pkg::scmc_state_type next_st;
  logic deep;
  logic hlim_hit;
  logic llim_hit;
  logic want_high;
  logic [10:0] hlim;
  logic [10:0] llim;
  logic [scmc_pkg::EV_W-1:0] ev;
  logic [7:0] cmc_view;

  // Deep sleep drops the substitute clock unless something keeps it.
  assign deep = (st.mode == scmc_pkg::ST_SLEEP) && !sub_keep_on;
  assign want_high = st.hsel || (st.div_sel > scmc_pkg::DIV_LOW_MAX);
  assign hlim = high_is_crystal ? scmc_pkg::XTAL_CYCLES
                                : scmc_pkg::HIGH_SPEED_INTERNAL_RC_CYCLES;
  assign llim = low_is_crystal ? scmc_pkg::XTAL_CYCLES
                               : scmc_pkg::LOW_SPEED_INTERNAL_RC_CYCLES;
  assign hlim_hit = high_osc_tick && (st.hcnt + 11'h001 >= hlim);
  assign llim_hit = low_osc_tick && (st.lcnt + 11'h001 >= llim);

  // The high oscillator runs only while the high clock is wanted and
  // the mode is neither sleep nor idle with the clock stopped; the low one dies in deep sleep.
  assign high_osc_enable = want_high
    && (st.mode != scmc_pkg::ST_SLEEP)
    && (st.mode != scmc_pkg::ST_IDLE_OFF);
  assign low_osc_enable = !deep;

  // ****************************************************************
  // Clock steering
  // ****************************************************************
  // The substitute clock carries the core while the crystal settles.
  always_comb begin
    sysclk_div_shift = 3'h0;
    if ((st.mode == scmc_pkg::ST_SLEEP)
        || (st.mode == scmc_pkg::ST_IDLE_OFF)
        || (st.mode == scmc_pkg::ST_WAKE)) begin
      sysclk_src = scmc_pkg::SRC_OFF;
    end else if (st.fast_act) begin
      sysclk_src = scmc_pkg::SRC_SUB;
    end else if (st.hsel) begin
      sysclk_src = scmc_pkg::SRC_HIGH;
    end else if (st.div_sel <= scmc_pkg::DIV_LOW_MAX) begin
      sysclk_src = scmc_pkg::SRC_LOW;
    end else begin
      sysclk_src = scmc_pkg::SRC_DIV;
      sysclk_div_shift = 3'(scmc_pkg::DIV_SHIFT_BASE
                            - {1'b0, st.div_sel});
    end
  end

  assign sysclk_run = (sysclk_src != scmc_pkg::SRC_OFF);
  assign cpu_run = (st.mode == scmc_pkg::ST_RUN);
  assign irq = |(st.status & st.mask);
  assign reg_rdata = st.rdata;

  // Ready flags read live; the stored copies of those bits do not exist.
  assign cmc_view = {st.div_sel, st.fast_en, st.lready, st.hready,
                     st.idle_on_halt, st.hsel};

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    ev = '0;
    next_st.rdata = 8'h00;

    // Oscillator counters restart whenever their oscillator is off.
    if (!high_osc_enable) begin
      next_st.hcnt = 11'h000;
      next_st.hready = 1'b0;
    end else if (!st.hready && high_osc_tick) begin
      next_st.hcnt = st.hcnt + 11'h001;
      if (hlim_hit) begin
        next_st.hready = 1'b1;
        ev[scmc_pkg::EV_HRDY] = 1'b1;
      end
    end
    if (!low_osc_enable) begin
      next_st.lcnt = 11'h000;
      next_st.lready = 1'b0;
    end else if (!st.lready && low_osc_tick) begin
      next_st.lcnt = st.lcnt + 11'h001;
      if (llim_hit) begin
        next_st.lready = 1'b1;
        ev[scmc_pkg::EV_LRDY] = 1'b1;
      end
    end
    if (next_st.hready || !want_high) begin
      next_st.fast_act = 1'b0;
    end

    // Power mode sequencing.
    unique case (st.mode)
      scmc_pkg::ST_RUN: begin
        if (halt_req) begin
          ev[scmc_pkg::EV_HALT] = 1'b1;
          if (!st.idle_on_halt) begin
            next_st.mode = scmc_pkg::ST_SLEEP;
          end else if (st.keep) begin
            next_st.mode = scmc_pkg::ST_IDLE_ON;
          end else begin
            next_st.mode = scmc_pkg::ST_IDLE_OFF;
          end
        end
      end
      scmc_pkg::ST_IDLE_ON: begin
        if (wake_req) begin
          next_st.mode = scmc_pkg::ST_RUN;
          ev[scmc_pkg::EV_WAKE] = 1'b1;
        end
      end
      scmc_pkg::ST_IDLE_OFF, scmc_pkg::ST_SLEEP: begin
        if (wake_req) begin
          next_st.mode = scmc_pkg::ST_WAKE;
          ev[scmc_pkg::EV_WAKE] = 1'b1;
          // Fast wake needs the substitute clock, so not from deep.
          next_st.fast_act = st.fast_en && high_is_crystal
                             && want_high && !deep;
        end
      end
      scmc_pkg::ST_WAKE: begin
        // Without fast wake the core waits for its own oscillator.
        if (st.fast_act
            || (want_high ? st.hready : st.lready)) begin
          next_st.mode = scmc_pkg::ST_RUN;
        end
      end
      default: begin
        next_st.mode = scmc_pkg::ST_WAKE;
      end
    endcase

    // Register writes.
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        scmc_pkg::CMC_OFF: begin
          next_st.div_sel = reg_req.wdata[scmc_pkg::DIV_LSB +: 3];
          next_st.fast_en = reg_req.wdata[scmc_pkg::FAST_BIT];
          next_st.idle_on_halt = reg_req.wdata[scmc_pkg::IDLE_BIT];
          next_st.hsel = reg_req.wdata[scmc_pkg::HSEL_BIT];
        end
        scmc_pkg::WDC_OFF: begin
          next_st.keep = reg_req.wdata[scmc_pkg::KEEP_BIT];
        end
        scmc_pkg::MASK_OFF: begin
          next_st.mask = reg_req.wdata[scmc_pkg::EV_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Reads answer next cycle; reading status clears it, but a new
    // event in the same cycle survives the clear.
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        scmc_pkg::CMC_OFF: next_st.rdata = cmc_view;
        scmc_pkg::WDC_OFF: next_st.rdata = {7'h00, st.keep};
        scmc_pkg::STAT_OFF: begin
          next_st.rdata = {4'h0, st.status};
          next_st.status = '0;
        end
        scmc_pkg::MASK_OFF: next_st.rdata = {4'h0, st.mask};
        default: next_st.rdata = 8'h00;
      endcase
    end
    next_st.status = next_st.status | ev;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Power-on starts in the wake wait, so code runs with high ready.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st.mode <= scmc_pkg::ST_WAKE;
      st.div_sel <= scmc_pkg::CMC_RESET[scmc_pkg::DIV_LSB +: 3];
      st.fast_en <= scmc_pkg::CMC_RESET[scmc_pkg::FAST_BIT];
      st.idle_on_halt <= scmc_pkg::CMC_RESET[scmc_pkg::IDLE_BIT];
      st.hsel <= scmc_pkg::CMC_RESET[scmc_pkg::HSEL_BIT];
      st.keep <= scmc_pkg::WDC_KEEP_RESET;
      st.fast_act <= 1'b0;
      st.hcnt <= 11'h000;
      st.lcnt <= 11'h000;
      st.hready <= 1'b0;
      st.lready <= 1'b0;
      st.status <= '0;
      st.mask <= '0;
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  div_select_a: assert property (
    (cpu_run && !st.fast_act && !st.hsel && st.div_sel[2:1] != 2'h0)
    |-> (sysclk_src == scmc_pkg::SRC_DIV)
        && ({1'b0, sysclk_div_shift} + {1'b0, st.div_sel}
            == scmc_pkg::DIV_SHIFT_BASE))
    else $error("Divided clock not selected.");

  low_select_a: assert property (
    (cpu_run && !st.fast_act && !st.hsel && st.div_sel[2:1] == 2'h0)
    |-> (sysclk_src == scmc_pkg::SRC_LOW) && !high_osc_enable)
    else $error("Low clock not selected.");

  high_select_a: assert property (
    (cpu_run && !st.fast_act && st.hsel)
    |-> sysclk_src == scmc_pkg::SRC_HIGH)
    else $error("Full high clock not selected.");

  high_stop_a: assert property (
    (cpu_run && !want_high) |=> !st.hready)
    else $error("High oscillator kept running on low clock.");

  fast_wake_a: assert property (
    (st.mode == scmc_pkg::ST_WAKE && st.fast_act && !st.hready)
    |=> cpu_run && sysclk_src == scmc_pkg::SRC_SUB)
    else $error("Fast wake did not run on substitute clock.");

  low_deep_a: assert property (
    deep |=> !st.lready)
    else $error("Low ready set in deep sleep.");

  high_sleep_a: assert property (
    (st.mode == scmc_pkg::ST_SLEEP || st.mode == scmc_pkg::ST_IDLE_OFF)
    |=> !st.hready)
    else $error("High ready set while clock stopped.");

  cpu_ready_a: assert property (
    $rose(cpu_run) && !st.fast_act |-> (want_high ? st.hready : st.lready))
    else $error("Core started before oscillator ready.");

  halt_mode_a: assert property (
    (cpu_run && halt_req) |=>
      st.mode == ($past(st.idle_on_halt)
        ? ($past(st.keep) ? scmc_pkg::ST_IDLE_ON : scmc_pkg::ST_IDLE_OFF)
        : scmc_pkg::ST_SLEEP))
    else $error("Halt entered the wrong mode.");

  idle_clock_a: assert property (
    st.mode == scmc_pkg::ST_IDLE_ON |-> !cpu_run && sysclk_run)
    else $error("Idle with clock kept is wrong.");

  // Stopping the clock in idle must also stop the core.
  idle_stop_a: assert property (
    st.mode == scmc_pkg::ST_IDLE_OFF |-> !cpu_run && !sysclk_run)
    else $error("Idle with clock stopped still runs.");

  // Once the high oscillator is stable the substitute clock must go.
  fast_end_a: assert property (
    (cpu_run && st.hready && want_high) |-> !st.fast_act)
    else $error("Substitute clock kept after high ready.");

  // A status read with no new event leaves nothing pending.
  status_clear_a: assert property (
    (reg_req.rd && reg_req.addr == scmc_pkg::STAT_OFF && ev == '0)
    |=> st.status == '0)
    else $error("Status read did not clear events.");

  ready_read_a: assert property (
    (reg_req.rd && reg_req.addr == scmc_pkg::CMC_OFF)
    |=> reg_rdata[scmc_pkg::HRDY_BIT] == $past(st.hready))
    else $error("High ready read does not show hardware.");

endmodule : scmc_top

// >>> testbench/scmc_top_test.sv
module scmc_top_test;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Stimulus and observation signals
  // ****************************************************************
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  scmc_pkg::scmc_bus_req_type reg_req = '0;
  logic [7:0] reg_rdata;
  logic high_is_crystal = 1'b0;
  logic low_is_crystal = 1'b0;
  logic high_osc_tick = 1'b1;
  logic low_osc_tick = 1'b1;
  logic sub_keep_on = 1'b0;
  logic halt_req = 1'b0;
  logic wake_req = 1'b0;
  logic cpu_run;
  logic sysclk_run;
  scmc_pkg::scmc_src_type sysclk_src;
  logic [2:0] sysclk_div_shift;
  logic high_osc_enable;
  logic low_osc_enable;
  logic irq;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  logic [7:0] rd;

  scmc_top scmc_top_i (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .high_is_crystal(high_is_crystal),
    .low_is_crystal(low_is_crystal),
    .high_osc_tick(high_osc_tick),
    .low_osc_tick(low_osc_tick),
    .sub_keep_on(sub_keep_on),
    .halt_req(halt_req),
    .wake_req(wake_req),
    .cpu_run(cpu_run),
    .sysclk_run(sysclk_run),
    .sysclk_src(sysclk_src),
    .sysclk_div_shift(sysclk_div_shift),
    .high_osc_enable(high_osc_enable),
    .low_osc_enable(low_osc_enable),
    .irq(irq)
  );

  // The oscillator ticks stay high, so one tick lands on every edge.
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe, so take them there.
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_rd

  task automatic pulse_halt;
    @(posedge ref_clk);
    halt_req <= 1'b1;
    @(posedge ref_clk);
    halt_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : pulse_halt

  task automatic pulse_wake;
    @(posedge ref_clk);
    wake_req <= 1'b1;
    @(posedge ref_clk);
    wake_req <= 1'b0;
    #1;
  endtask : pulse_wake

  // A bounded wait keeps a stuck mode machine from hanging the run.
  task automatic wait_run(input int limit);
    n = 0;
    while (cpu_run !== 1'b1 && n < limit) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(8'(cpu_run), 8'h01, "core not running");
  endtask : wait_run

  task automatic tally_and_finish;
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // A hung wait is cut off well past the longest crystal count.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge ref_clk);
    chk(8'(cpu_run), 8'h00, "core ran in reset");
    rst <= 1'b0;
    wait_run(40);
    reg_rd(scmc_pkg::CMC_OFF, rd);
    chk(rd, 8'h0f, "cmc after power-on");
    reg_wr(scmc_pkg::CMC_OFF, 8'h03);
    reg_rd(scmc_pkg::CMC_OFF, rd);
    chk(rd, 8'h0f, "ready bits written");
    reg_rd(8'h10, rd);
    chk(rd, 8'h00, "unmapped read");
    // Walk the divider field from fastest down to the low clock codes.
    for (int d = 7; d >= 0; d--) begin
      reg_wr(scmc_pkg::CMC_OFF, 8'(d << 5) | 8'h02);
      repeat (20) @(posedge ref_clk);
      #1;
      if (d >= 2) begin
        chk(8'(sysclk_src), 8'(scmc_pkg::SRC_DIV), "div src");
        chk(8'(sysclk_div_shift), 8'(8 - d), "div shift");
      end else begin
        chk(8'(sysclk_src), 8'(scmc_pkg::SRC_LOW), "low src");
        chk(8'(high_osc_enable), 8'h00, "high osc left on");
        chk(8'(sysclk_div_shift), 8'h00, "low shift");
      end
    end
    reg_wr(scmc_pkg::CMC_OFF, 8'h03);
    repeat (20) @(posedge ref_clk);
    #1;
    chk(8'(sysclk_src), 8'(scmc_pkg::SRC_HIGH), "high src");
    // Idle with the clock kept, events masked off at first.
    reg_wr(scmc_pkg::MASK_OFF, 8'h00);
    reg_wr(scmc_pkg::WDC_OFF, 8'h01);
    reg_rd(scmc_pkg::WDC_OFF, rd);
    chk(rd, 8'h01, "keep bit readback");
    pulse_halt();
    chk(8'(cpu_run), 8'h00, "cpu in idle on");
    chk(8'(sysclk_run), 8'h01, "clock in idle on");
    chk(8'(irq), 8'h00, "masked irq");
    pulse_wake();
    wait_run(2);
    reg_wr(scmc_pkg::MASK_OFF, 8'h04);
    #1;
    chk(8'(irq), 8'h01, "unmasked irq");
    reg_rd(scmc_pkg::MASK_OFF, rd);
    chk(rd, 8'h04, "mask readback");
    reg_rd(scmc_pkg::STAT_OFF, rd);
    chk(rd, 8'h0f, "ready, halt and wake events");
    @(posedge ref_clk);
    #1;
    chk(8'(irq), 8'h00, "irq after status read");
    // Idle with the system clock stopped drops the high ready flag.
    reg_wr(scmc_pkg::WDC_OFF, 8'h00);
    pulse_halt();
    chk(8'(cpu_run), 8'h00, "cpu in idle off");
    chk(8'(sysclk_run), 8'h00, "clock in idle off");
    reg_rd(scmc_pkg::CMC_OFF, rd);
    chk(rd & 8'h04, 8'h00, "high ready in idle off");
    pulse_wake();
    wait_run(40);
    // Deep sleep stops both oscillators and clears the low flag.
    @(posedge ref_clk);
    low_is_crystal <= 1'b1;
    reg_wr(scmc_pkg::CMC_OFF, 8'h01);
    pulse_halt();
    chk(8'(cpu_run), 8'h00, "cpu in sleep");
    chk(8'(sysclk_run), 8'h00, "clock in sleep");
    chk(8'(high_osc_enable), 8'h00, "high osc in sleep");
    chk(8'(low_osc_enable), 8'h00, "low osc in deep sleep");
    reg_rd(scmc_pkg::CMC_OFF, rd);
    chk(rd & 8'h0c, 8'h00, "ready flags in deep sleep");
    pulse_wake();
    wait_run(40);
    // The low crystal needs its long count before its flag rises.
    reg_rd(scmc_pkg::CMC_OFF, rd);
    chk(rd & 8'h0c, 8'h04, "low crystal still settling");
    repeat (1024) @(posedge ref_clk);
    reg_rd(scmc_pkg::CMC_OFF, rd);
    chk(rd & 8'h0c, 8'h0c, "low crystal ready");
    // Fast wake on the crystal runs on the substitute clock first.
    @(posedge ref_clk);
    high_is_crystal <= 1'b1;
    sub_keep_on <= 1'b1;
    reg_wr(scmc_pkg::CMC_OFF, 8'h11);
    reg_rd(scmc_pkg::CMC_OFF, rd);
    chk(rd, 8'h1d, "fast enable readback");
    pulse_halt();
    pulse_wake();
    repeat (2) @(posedge ref_clk);
    #1;
    chk(8'(cpu_run), 8'h01, "fast wake run");
    chk(8'(sysclk_src), 8'(scmc_pkg::SRC_SUB), "substitute src");
    n = 2;
    while (sysclk_src === scmc_pkg::SRC_SUB && n < 1100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(8'(n >= 1020 && n <= 1030), 8'h01, "substitute span");
    chk(8'(sysclk_src), 8'(scmc_pkg::SRC_HIGH), "crystal src");
    reg_rd(scmc_pkg::CMC_OFF, rd);
    chk(rd & 8'h04, 8'h04, "high ready after fast wake");
    tally_and_finish();
  end

endmodule : scmc_top_test
